//--- design/srfrd_top.sv
// rollback indicator latches, rollup indication and avalon-mm register slave
// assumes cause and feedback inputs come from logic on clk_sys
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module srfrd_top
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [15:0] speed_fb,
  input wire logic [srfrd_pkg::NUM_SRC-1:0] rb_cause,
  output logic [srfrd_pkg::NUM_SRC-1:0] src_rb_ind,
  output logic any_rb_ind,
  output logic rollup_active_ind,
  output logic rollup_inhibit_ctl,
  output logic signed [15:0] ramp_out,
  output logic signed [15:0] torque_ref
);
  import srfrd_pkg::*;

  srfrd_ctl_if c ();

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic inhibit_reg;
  logic clr_tog_reg;
  logic clr_seen_reg;
  logic signed [15:0] tmax_reg;
  logic signed [15:0] tmin_reg;
  logic signed [15:0] demand_reg;
  logic [NUM_SRC-1:0] src_reg;
  logic any_reg;
  logic rollup_reg;
  logic hold;
  logic access;
  logic wr_go;
  logic rd_go;
  logic clr_pulse;
  logic rollback_eff;
  logic [31:0] rdata_next;

  srfrd_regulator u_reg
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .speed_fb(speed_fb),
    .tmax(tmax_reg),
    .tmin(tmin_reg),
    .c(c.regu)
  );

  srfrd_ramp u_ramp
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .demand(demand_reg),
    .speed_fb(speed_fb),
    .inhibit(inhibit_reg),
    .hold(hold),
    .c(c.rmp)
  );

  assign access = avs_read || avs_write;
  assign wr_go = avs_write && !wait_reg;
  assign rd_go = avs_read && wait_reg;
  // a toggle, not a level, so a stuck program bit cannot mask new events
  assign clr_pulse = clr_tog_reg != clr_seen_reg; // RQ5
  // rollback is only in effect while not inhibited
  assign rollback_eff = (c.at_max || c.at_min) && !inhibit_reg; // RQ8 RQ14
  // every access waits exactly one cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wait_reg <= 1'b1;
    end
    else
    begin
      wait_reg <= !(access && wait_reg);
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      ADDR_CTRL:
      begin
        rdata_next[CTRL_INHIBIT] = inhibit_reg;
        rdata_next[CTRL_CLR_TOG] = clr_tog_reg;
      end
      ADDR_STATUS:
      begin
        rdata_next[NUM_SRC-1:0] = src_reg;
        rdata_next[ST_ANY] = any_reg;
        rdata_next[ST_ROLLUP] = rollup_reg;
        rdata_next[ST_AT_MAX] = c.at_max;
        rdata_next[ST_AT_MIN] = c.at_min;
        rdata_next[ST_HOLD] = hold;
      end
      ADDR_TMAX: rdata_next[15:0] = tmax_reg;
      ADDR_TMIN: rdata_next[15:0] = tmin_reg;
      ADDR_DEMAND: rdata_next[15:0] = demand_reg;
      ADDR_RAMP: rdata_next[15:0] = c.ramp;
      ADDR_TORQUE: rdata_next[15:0] = c.torque;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // program-owned controls; inhibit level needs no conditioning
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      inhibit_reg <= 1'b0;
      clr_tog_reg <= 1'b0;
      tmax_reg <= TMAX_RST;
      tmin_reg <= TMIN_RST;
      demand_reg <= 16'sh0000;
    end
    else if (wr_go)
    begin
      case (avs_address)
        ADDR_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            inhibit_reg <= avs_writedata[CTRL_INHIBIT]; // RQ9
            clr_tog_reg <= avs_writedata[CTRL_CLR_TOG];
          end
        end
        ADDR_TMAX: tmax_reg <= srfrd_be16(tmax_reg, avs_writedata, avs_byteenable);
        ADDR_TMIN: tmin_reg <= srfrd_be16(tmin_reg, avs_writedata, avs_byteenable);
        ADDR_DEMAND: demand_reg <= srfrd_be16(demand_reg, avs_writedata, avs_byteenable);
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clr_seen_reg <= 1'b0;
    end
    else
    begin
      clr_seen_reg <= clr_tog_reg;
    end
  end

  // set beats clear, so a still-active cause reappears at once
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      src_reg <= '0;
      any_reg <= 1'b0;
    end
    else
    begin
      src_reg <= (src_reg & ~{NUM_SRC{clr_pulse}}) | (rb_cause & {NUM_SRC{rollback_eff}}); // RQ1 RQ2 RQ3 RQ5 RQ16
      any_reg <= (any_reg && !clr_pulse) || rollback_eff; // RQ4 RQ5 RQ16
    end
  end

  // live, unlatched, and shown even when inhibited
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rollup_reg <= 1'b0;
    end
    else
    begin
      rollup_reg <= c.at_min && (c.ramp < speed_fb); // RQ6 RQ10
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign src_rb_ind = src_reg;
  assign any_rb_ind = any_reg;
  assign rollup_active_ind = rollup_reg;
  assign rollup_inhibit_ctl = inhibit_reg;
  assign ramp_out = c.ramp;
  assign torque_ref = c.torque;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_LATCH_HOLD: assert property ( // RQ1
    !clr_pulse |=> ((src_reg & $past(src_reg)) == $past(src_reg)) && (any_reg || !$past(any_reg)))
    else $error("rollback flag dropped without a clear");

  AST_SRC_SET: assert property ( // RQ2
    rollback_eff |=> ((src_reg & $past(rb_cause)) == $past(rb_cause)))
    else $error("active cause did not set its flag");

  AST_SRC_ONLY: assert property ( // RQ3
    ##1 (((src_reg & ~$past(src_reg)) & ~$past(rb_cause)) == '0))
    else $error("flag set without its cause");

  AST_ANY_SET: assert property ( // RQ4
    rollback_eff |=> any_reg)
    else $error("generic flag missed a rollback");

  AST_CLEAR: assert property ( // RQ5
    clr_pulse && !rollback_eff |=> (src_reg == '0) && !any_reg)
    else $error("clear left a flag set");

  AST_RESET_AGAIN: assert property ( // RQ16
    clr_pulse && rollback_eff && rb_cause[MENU_LIMIT_RB_IND] |=> src_reg[MENU_LIMIT_RB_IND] && any_reg)
    else $error("active cause lost by clear");

  AST_ROLLUP_LIVE: assert property ( // RQ6
    ##1 (rollup_active_ind == $past(c.at_min && (c.ramp < speed_fb))))
    else $error("rollup indication not following condition");

  AST_ROLLUP_INH: assert property ( // RQ10
    inhibit_reg && c.at_min && (c.ramp < speed_fb) |=> rollup_active_ind)
    else $error("rollup indication suppressed by inhibit");

  AST_INHIBIT: assert property ( // RQ8
    inhibit_reg ##1 inhibit_reg |-> !$rose(any_rb_ind))
    else $error("rollback seen while inhibited");

  AST_ROLLBACK: assert property ( // RQ14
    !inhibit_reg && c.at_max |=>
      c.ramp == srfrd_clamp(18'($past(speed_fb)) + 18'(EQ_MARGIN), SPD_MIN, SPD_MAX))
    else $error("ramp not reloaded at rollback");

  AST_ROLLUP_UP: assert property ( // RQ7
    !inhibit_reg && c.at_min |=>
      c.ramp == srfrd_clamp(18'($past(speed_fb)) - 18'(EQ_MARGIN), SPD_MIN, SPD_MAX))
    else $error("ramp not driven to equilibrium in rollup");

  AST_HOLD: assert property ( // RQ12
    inhibit_reg && speed_fb >= LOW_SPD && c.ramp >= LOW_SPD |=> c.ramp >= LOW_SPD)
    else $error("inhibited ramp fell below floor");

  AST_RELEASE: assert property ( // RQ13
    inhibit_reg && speed_fb < LOW_SPD && demand_reg < c.ramp |=> c.ramp < $past(c.ramp))
    else $error("hold not released at low speed");

  AST_NORMAL: assert property ( // RQ11
    inhibit_reg && c.ramp > LOW_SPD && demand_reg > c.ramp |=> c.ramp > $past(c.ramp))
    else $error("inhibited ramp not running normally");

  AST_NO_WINDUP: assert property ( // RQ15
    $past(tmin_reg) <= $past(tmax_reg) |-> (torque_ref <= $past(tmax_reg)) && (torque_ref >= $past(tmin_reg)))
    else $error("torque ref beyond active limit");

  AST_WAIT_ONE: assert property (
    access && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not a single low cycle");

  AST_WAIT_IDLE: assert property (
    !access |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  AST_RD_STABLE: assert property (
    !rd_go |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  AST_FLAG_FROZEN: assert property ( // RQ8
    !rollback_eff && !clr_pulse |=> (src_reg == $past(src_reg)) && (any_reg == $past(any_reg)))
    else $error("flags changed with no rollback in effect");

  AST_CLEAR_ANY: assert property ( // RQ16
    clr_pulse && rollback_eff |=> any_reg)
    else $error("generic flag lost by clear during rollback");

  AST_HOLD_FLOOR: assert property ( // RQ12
    hold |-> c.ramp <= LOW_SPD)
    else $error("held ramp above the floor");

  AST_AT_EXCL: assert property ( // RQ14
    !(c.at_max && c.at_min))
    else $error("both torque limits flagged active");
endmodule : srfrd_top

//--- design/srfrd_pkg.sv
// constants, register map and helpers for the rollback flag and rollup-inhibit block
// assumes one 100 MHz clock and a 32-bit avalon-mm slave port
// Operation
// RQ1: rollback flags stay set until cleared
// RQ2: ten cause-specific sticky rollback flags
// RQ3: causes: menu, cell, phase, voltage, field, thermal...
// RQ4: generic flag latches on any rollback
// RQ5: program toggles clear bit; all eleven clear
// RQ6: rollup indication live, regen limit plus rollup
// RQ7: rollup drives ramp up to equilibrium
// RQ8: inhibit suppresses all rollback, both limits
// RQ9: program sets inhibit freely; same behaviour
// RQ10: rollup indication still shown when inhibited
// RQ11: inhibited above 10 percent: ramp runs normally
// RQ12: inhibited ramp held at 10 percent floor
// RQ13: hold released when speed below 10 percent
// RQ14: clamp, record limit, roll back, reload ramp
// RQ15: integrator stops at active limit, no windup
// RQ16: active cause sets flags again after clear
package srfrd_pkg;
  localparam int NUM_SRC = 10;
  localparam int MENU_LIMIT_RB_IND = 0;
  localparam int CELL_OVERLOAD_RB_IND = 1;
  localparam int PHASE_LOSS_RB_IND = 2;
  localparam int LOW_VOLTAGE_RB_IND = 3;
  localparam int FIELD_WEAKEN_RB_IND = 4;
  localparam int THERMAL_OVERLOAD_RB_IND = 5;
  localparam int NET_A_LIMIT_RB_IND = 6;
  localparam int NET_B_LIMIT_RB_IND = 7;
  localparam int ANALOG_LIMIT_RB_IND = 8;
  localparam int REGEN_OVERVOLT_RB_IND = 9;
  // byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_TMAX = 5'h08;
  localparam logic [4:0] ADDR_TMIN = 5'h0c;
  localparam logic [4:0] ADDR_DEMAND = 5'h10;
  localparam logic [4:0] ADDR_RAMP = 5'h14;
  localparam logic [4:0] ADDR_TORQUE = 5'h18;
  // ctrl fields
  localparam int CTRL_INHIBIT = 0;
  localparam int CTRL_CLR_TOG = 1;
  // status fields above the ten source flags
  localparam int ST_ANY = 10;
  localparam int ST_ROLLUP = 11;
  localparam int ST_AT_MAX = 12;
  localparam int ST_AT_MIN = 13;
  localparam int ST_HOLD = 14;
  localparam logic signed [15:0] TMAX_RST = 16'sh2000;
  localparam logic signed [15:0] TMIN_RST = -16'sh2000;
  localparam logic signed [15:0] RATED_SPD = 16'sh4000;
  localparam int LOW_SPD_PCT = 10;
  localparam logic signed [15:0] LOW_SPD = 16'((32'(RATED_SPD) * LOW_SPD_PCT) / 100);
  localparam logic signed [15:0] SPD_MAX = 16'sh7fff;
  localparam logic signed [15:0] SPD_MIN = -16'sh7fff;
  localparam logic signed [15:0] RAMP_STEP = 16'sh0010;
  localparam logic signed [15:0] EQ_MARGIN = 16'sh0100;
  localparam int KI_SHIFT = 2;

  function automatic logic signed [15:0] srfrd_clamp(input logic signed [17:0] v,
                                                     input logic signed [15:0] lo,
                                                     input logic signed [15:0] hi);
    if (v > hi)
    begin
      return hi;
    end
    else if (v < lo)
    begin
      return lo;
    end
    return 16'(v);
  endfunction : srfrd_clamp

  function automatic logic [15:0] srfrd_be16(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : srfrd_be16
endpackage : srfrd_pkg

//--- design/srfrd_ctl_if.sv
// ramp and regulator signals shared between the block's own modules
// assumes all parties run on clk_sys
`timescale 1ns/1ps
interface srfrd_ctl_if;
  logic signed [15:0] ramp;
  logic signed [15:0] torque;
  logic at_max;
  logic at_min;
  modport regu (input ramp, output torque, output at_max, output at_min);
  modport rmp (output ramp, input at_max, input at_min);
  modport mon (input ramp, input torque, input at_max, input at_min);
endinterface : srfrd_ctl_if

//--- design/srfrd_regulator.sv
// integral speed regulator with clamped torque output
// assumes limits and feedback come from logic on clk_sys
`timescale 1ns/1ps
module srfrd_regulator
  import srfrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic signed [15:0] speed_fb,
  input wire logic signed [15:0] tmax,
  input wire logic signed [15:0] tmin,
  srfrd_ctl_if.regu c
);
  logic signed [16:0] err;
  logic signed [17:0] sum;

  assign err = {c.ramp[15], c.ramp} - {speed_fb[15], speed_fb};
  assign sum = 18'(c.torque) + 18'(err >>> KI_SHIFT);

  // integrator is the torque ref; clamping it here stops windup
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      c.torque <= 16'sh0000;
      c.at_max <= 1'b0;
      c.at_min <= 1'b0;
    end
    else
    begin
      c.torque <= srfrd_clamp(sum, tmin, tmax); // RQ15
      c.at_max <= (sum >= tmax); // RQ14
      c.at_min <= (sum <= tmin) && (sum < tmax); // RQ14
    end
  end
endmodule : srfrd_regulator

//--- design/srfrd_ramp.sv
// speed ramp with rollback reload and the inhibited low-speed hold
// assumes forward rotation only; negative speeds are not treated
`timescale 1ns/1ps
module srfrd_ramp
  import srfrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic signed [15:0] demand,
  input wire logic signed [15:0] speed_fb,
  input wire logic inhibit,
  output logic hold,
  srfrd_ctl_if.rmp c
);
  logic signed [15:0] step_val;
  logic signed [15:0] eq_val;
  logic signed [15:0] ramp_next;
  logic hold_next;

  always_comb
  begin
    if (demand > c.ramp)
    begin
      step_val = srfrd_clamp(18'(c.ramp) + 18'(RAMP_STEP), c.ramp, demand);
    end
    else
    begin
      step_val = srfrd_clamp(18'(c.ramp) - 18'(RAMP_STEP), demand, c.ramp);
    end
    // equilibrium keeps the regulator pressed against its clamp
    if (c.at_max)
    begin
      eq_val = srfrd_clamp(18'(speed_fb) + 18'(EQ_MARGIN), SPD_MIN, SPD_MAX);
    end
    else
    begin
      eq_val = srfrd_clamp(18'(speed_fb) - 18'(EQ_MARGIN), SPD_MIN, SPD_MAX);
    end
    hold_next = 1'b0;
    ramp_next = step_val; // RQ11 RQ13
    if (!inhibit && (c.at_max || c.at_min))
    begin
      ramp_next = eq_val; // RQ14 RQ7
    end
    // only a falling ramp is held; a rising one below the floor must pass
    else if (inhibit && step_val < c.ramp && step_val < LOW_SPD && speed_fb >= LOW_SPD)
    begin
      hold_next = 1'b1; // RQ12
      ramp_next = (c.ramp < LOW_SPD) ? c.ramp : LOW_SPD; // RQ12
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      c.ramp <= 16'sh0000;
      hold <= 1'b0;
    end
    else
    begin
      c.ramp <= ramp_next;
      hold <= hold_next;
    end
  end
endmodule : srfrd_ramp

//--- tb/srfrd_uop_model.sv
// operating program model: avalon-mm master that reads flags and sets ctrl
// assumes the slave answers with waitrequest low, on clk_sys
`timescale 1ns/1ps
module srfrd_uop_model
  import srfrd_pkg::*;
(
  input wire logic clk_sys,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  logic tog = 1'b0;
  logic inh = 1'b0;

  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // request held until the edge that samples waitrequest low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer

  // clear is a toggle, so the stored bit flips on every clear
  task automatic ctl(input logic inhibit, input logic clr);
    logic [31:0] q;
    inh = inhibit;
    tog = tog ^ clr;
    xfer(1'b1, ADDR_CTRL, {30'h0, tog, inh}, q);
  endtask : ctl
endmodule : srfrd_uop_model

//--- tb/srfrd_tb.sv
// self-checking bench for srfrd_top, bus driven by the program model
// assumes srfrd_pkg constants and a 100 MHz clk_sys
`timescale 1ns/1ps
module srfrd_tb;
  import srfrd_pkg::*;
  logic clk_sys;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signed [15:0] speed_fb;
  logic [NUM_SRC-1:0] rb_cause;
  logic [NUM_SRC-1:0] src_rb_ind;
  logic any_rb_ind;
  logic rollup_active_ind;
  logic rollup_inhibit_ctl;
  logic signed [15:0] ramp_out;
  logic signed [15:0] torque_ref;
  logic [10:0] ind;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [4:0] ra [7] = '{ADDR_CTRL, ADDR_STATUS, ADDR_TMAX, ADDR_TMIN, ADDR_DEMAND, ADDR_RAMP, 5'h1c};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h2000, 32'he000, 32'h0, 32'h0, 32'h0};

  assign ind = {any_rb_ind, src_rb_ind};

  srfrd_top i_srfrd_top (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .speed_fb(speed_fb),
    .rb_cause(rb_cause), .src_rb_ind(src_rb_ind), .any_rb_ind(any_rb_ind),
    .rollup_active_ind(rollup_active_ind), .rollup_inhibit_ctl(rollup_inhibit_ctl),
    .ramp_out(ramp_out), .torque_ref(torque_ref));

  srfrd_uop_model i_srfrd_uop_model (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // generic flag follows rollback in effect, not the causes
  function automatic logic [10:0] exp_ind(input logic [NUM_SRC-1:0] c, input logic rb);
    return rb ? {1'b1, c} : 11'h0;
  endfunction : exp_ind

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_ind(input logic [10:0] got, input logic [10:0] exp, input string what);
    chk_reg({21'h0, got}, {21'h0, exp}, what);
  endtask : chk_ind

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    i_srfrd_uop_model.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_srfrd_uop_model.xfer(1'b1, a, d, q);
  endtask : wr

  // bounded wait on a register field, then one comparison
  task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    logic [31:0] q;
    for (int i = 0; i < 400; i++)
    begin
      rd(a, q);
      if ((q & m) === e)
        break;
    end
    chk_reg(q & m, e, what);
  endtask : poll

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // hang guard, well above the longest expected run
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  initial
  begin
    logic [31:0] q;
    logic [NUM_SRC-1:0] c;
    logic [NUM_SRC-1:0] c2;
    logic [NUM_SRC-1:0] hc;
    void'($urandom(95764));
    rst = 1'b1;
    speed_fb = 16'sh0000;
    rb_cause = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // read-only and unmapped writes must leave everything at reset
    wr(ADDR_RAMP, 32'h0000_1234);
    wr(5'h1c, 32'hffff_ffff);
    foreach (ra[i])
    begin
      rd(ra[i], q);
      chk_reg(q, rv[i], "reset value");
    end
    wr(ADDR_TMAX, 32'h0000_0100);
    wr(ADDR_DEMAND, 32'h0000_2000);
    poll(ADDR_STATUS, 32'h1 << ST_AT_MAX, 32'h1 << ST_AT_MAX, "at max");
    chk_reg({16'h0, torque_ref}, 32'h0000_0100, "torque clamp");
    chk_reg(32'(ramp_out <= EQ_MARGIN + RAMP_STEP), 32'h1, "ramp rolled back");
    // every cause alone, then random mixes; short pulses catch transitory latching
    for (int i = 0; i < 16; i++)
    begin
      c = (i < NUM_SRC) ? 10'h001 << i : 10'($urandom);
      c2 = 10'($urandom);
      hc = i[0] ? c2 : '0;
      rb_cause <= c;
      repeat (1 + $urandom_range(2)) @(posedge clk_sys);
      rb_cause <= '0;
      repeat (4) @(posedge clk_sys);
      chk_ind(ind, exp_ind(c, 1'b1), "one cause");
      rb_cause <= c2;
      @(posedge clk_sys);
      rb_cause <= hc;
      repeat (4) @(posedge clk_sys);
      chk_ind(ind, exp_ind(c | c2, 1'b1), "sticky");
      i_srfrd_uop_model.ctl(1'b0, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk_ind(ind, exp_ind(hc, 1'b1), "clear");
      rb_cause <= '0;
      i_srfrd_uop_model.ctl(1'b0, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk_ind(ind, exp_ind(10'h000, 1'b1), "cleared");
    end
    i_srfrd_uop_model.ctl(1'b1, 1'b1);
    rb_cause <= 10'h3ff;
    repeat (4) @(posedge clk_sys);
    chk_ind(ind, exp_ind(10'h3ff, 1'b0), "inhibited flags");
    chk_reg({31'h0, rollup_inhibit_ctl}, 32'h1, "inhibit out");
    rb_cause <= '0;
    poll(ADDR_RAMP, 32'hffff, 32'h2000, "ramp free at max");
    chk_reg({16'h0, torque_ref}, 32'h0000_0100, "still clamped");
    // rollup with rollback allowed
    i_srfrd_uop_model.ctl(1'b0, 1'b0);
    wr(ADDR_TMIN, 32'h0000_ff00);
    wr(ADDR_DEMAND, 32'h0);
    speed_fb <= 16'sh3000;
    poll(ADDR_STATUS, 32'h1 << ST_ROLLUP, 32'h1 << ST_ROLLUP, "rollup on");
    chk_reg(32'(ramp_out > 16'sh2000 && ramp_out < speed_fb), 32'h1, "ramp up");
    chk_reg({16'h0, torque_ref}, 32'h0000_ff00, "min clamp");
    speed_fb <= 16'sh0000;
    poll(ADDR_STATUS, 32'h1 << ST_ROLLUP, 32'h0, "rollup off");
    // inhibited: ramp runs normally above the floor, then holds, then releases
    i_srfrd_uop_model.ctl(1'b1, 1'b0);
    wr(ADDR_DEMAND, 32'h0000_2000);
    speed_fb <= 16'sh3000;
    poll(ADDR_RAMP, 32'hffff, 32'h2000, "ramp normal");
    chk_reg({31'h0, rollup_active_ind}, 32'h1, "rollup shown");
    wr(ADDR_DEMAND, 32'h0);
    poll(ADDR_STATUS, 32'h1 << ST_HOLD, 32'h1 << ST_HOLD, "hold");
    repeat (20) @(posedge clk_sys);
    chk_reg(32'(ramp_out >= LOW_SPD && ramp_out < LOW_SPD + RAMP_STEP), 32'h1, "floor");
    speed_fb <= 16'sh0400;
    poll(ADDR_RAMP, 32'hffff, 32'h0, "released");
    chk_reg({31'h0, rollup_inhibit_ctl}, 32'h1, "still inhibited");
    final_report();
  end
endmodule : srfrd_tb
